// ==== logic/bsr_pkg.sv ====
/*
  Shared constants and types for the brown-out and sleep regulator control block.
  Assumes a 20 MHz APB clock and a byte-addressed 12-bit APB address bus.
*/
package bsr_pkg;

  // APB geometry and register map.
  localparam int              ADDR_W   = 12;
  localparam logic [11:0]     BOC_OFS  = 12'h000;
  localparam logic [11:0]     REG_OFS  = 12'h004;
  localparam logic [11:0]     STAT_OFS = 12'h008;

  // Brownout control field positions.
  localparam int              SW_EN_BIT = 7;
  localparam int              FS_BIT    = 6;
  localparam int              RESV_HI   = 5;
  localparam int              RESV_LO   = 1;
  localparam int              RDY_BIT   = 0;

  // Regulator control field positions.
  localparam int              REGPM_BIT = 0;

  // Status field positions.
  localparam int              ST_SLEEP_BIT  = 0;
  localparam int              ST_LP_BIT     = 1;
  localparam int              ST_SETTLE_BIT = 2;
  localparam int              ST_SUP_BIT    = 3;
  localparam int              ST_BG_BIT     = 4;
  localparam int              ST_INC_BIT    = 5;
  localparam int              ST_CFG_LO     = 6;

  // Reset values.
  localparam logic            SW_EN_RST = 1'b1;
  localparam logic            FS_RST    = 1'b0;
  localparam logic            REGPM_RST = 1'b0;
  localparam logic [1:0]      CFG_RST   = 2'b00;
  localparam logic [31:0]     RDATA_RST = 32'h0000_0000;

  // Timing of the settle delay after a low-power sleep.
  localparam int              CLK_PERIOD_NS   = 50;
  localparam int              WAKE_SETTLE_NS  = 5000;
  localparam int              CNT_W           = 8;
  localparam logic [CNT_W-1:0] WAKE_SETTLE_CYC =
    CNT_W'((WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Supervisor configuration field encodings.
  typedef enum logic [1:0] {
    CFG_OFF     = 2'b00,
    CFG_SW      = 2'b01,
    CFG_NOSLEEP = 2'b10,
    CFG_ON      = 2'b11
  } bsr_cfg_mode_t;

  // Sleep sequencer states.
  typedef enum logic [1:0] {
    SEQ_RUN    = 2'b00,
    SEQ_SLEEP  = 2'b01,
    SEQ_SETTLE = 2'b10
  } bsr_seq_state_t;

endpackage

// ==== logic/bsr_ctl_if.sv ====
/*
  Carrier between the register side and the sleep sequencer.
  Assumes both ends run on the same pclk domain.
*/
`timescale 1ns/1ps
interface bsr_ctl_if;
  logic sleep_req;
  logic wake_evt;
  logic regpm;
  logic incompat_any;
  logic other_reset;
  logic in_sleep;
  logic low_power;
  logic core_run;
  logic settling;

  modport ctl (output sleep_req, wake_evt, regpm, incompat_any, other_reset,
               input  in_sleep, low_power, core_run, settling);
  modport seq (input  sleep_req, wake_evt, regpm, incompat_any, other_reset,
               output in_sleep, low_power, core_run, settling);
endinterface

// ==== logic/bsr_sleep_seq.sv ====
/*
  Sleep sequencer: selects the regulator power state in sleep and times the wake settle.
  Assumes sleep and wake requests come from logic on pclk.
*/
`timescale 1ns/1ps
module bsr_sleep_seq #(
  parameter bit UNREGULATED = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  bsr_ctl_if.seq   ctl
);

  bsr_pkg::bsr_seq_state_t     state_ff;
  bsr_pkg::bsr_seq_state_t     nxt_state;
  logic [bsr_pkg::CNT_W-1:0]   cnt_ff;
  logic                        lp_ff;
  logic                        nxt_lp;
  logic                        in_sleep_ff;
  logic                        run_ff;
  logic                        settle_ff;

  // The regulator drops to low power when software asks and nothing forbids it, or in every sleep when UNREGULATED is set.
  always_comb begin
    nxt_lp = 1'b0;
    if (nxt_state == bsr_pkg::SEQ_SLEEP) begin
      nxt_lp = UNREGULATED | (ctl.regpm & ~ctl.incompat_any);
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      bsr_pkg::SEQ_RUN: begin
        if (ctl.sleep_req) begin
          nxt_state = bsr_pkg::SEQ_SLEEP;
        end
      end
      bsr_pkg::SEQ_SLEEP: begin
        if (ctl.wake_evt) begin
          nxt_state = (lp_ff && !UNREGULATED) ? bsr_pkg::SEQ_SETTLE : bsr_pkg::SEQ_RUN;
        end
      end
      bsr_pkg::SEQ_SETTLE: begin
        if (cnt_ff == bsr_pkg::WAKE_SETTLE_CYC - 1'b1) begin
          nxt_state = bsr_pkg::SEQ_RUN;
        end
      end
      default: begin
        nxt_state = bsr_pkg::SEQ_RUN;
      end
    endcase
    if (ctl.other_reset) begin
      nxt_state = bsr_pkg::SEQ_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= bsr_pkg::SEQ_RUN;
      lp_ff       <= 1'b0;
      in_sleep_ff <= 1'b0;
      run_ff      <= 1'b1;
      settle_ff   <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      lp_ff       <= nxt_lp;
      in_sleep_ff <= (nxt_state == bsr_pkg::SEQ_SLEEP);
      run_ff      <= (nxt_state == bsr_pkg::SEQ_RUN);
      settle_ff   <= (nxt_state == bsr_pkg::SEQ_SETTLE);
    end
  end

  // Settle counter runs only while waiting after a low-power sleep.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (state_ff == bsr_pkg::SEQ_SETTLE) begin
      cnt_ff <= cnt_ff + 1'b1;
    end else begin
      cnt_ff <= '0;
    end
  end

  assign ctl.in_sleep  = in_sleep_ff;
  assign ctl.low_power = lp_ff;
  assign ctl.core_run  = run_ff;
  assign ctl.settling  = settle_ff;

  settle_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(settle_ff) && !ctl.other_reset |-> settle_ff && !run_ff
      ##1 (settle_ff || ctl.other_reset) [*4])
    else $error("settle ended too early");

  settle_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == bsr_pkg::SEQ_SETTLE && cnt_ff == bsr_pkg::WAKE_SETTLE_CYC - 1'b1
      |=> run_ff && !settle_ff)
    else $error("settle did not end on count");

  fast_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == bsr_pkg::SEQ_SLEEP && ctl.wake_evt && (!lp_ff || UNREGULATED)
      && !ctl.other_reset |=> run_ff)
    else $error("normal sleep wake was delayed");

  lp_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(in_sleep_ff) |-> lp_ff == (UNREGULATED | ($past(ctl.regpm) & !$past(ctl.incompat_any))))
    else $error("sleep power state wrong");

  settle_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(settle_ff) && run_ff);
  normal_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(in_sleep_ff) && run_ff);

endmodule

// ==== logic/bsr_ctrl.sv ====
/*
  Brown-out supervisor and sleep regulator control with an APB register file.
  Assumes the configuration field and supervisor status arrive asynchronously from
  the analog side, and sleep, wake and peripheral requests come from pclk logic.
*/
`timescale 1ns/1ps
module bsr_ctrl #(
  parameter bit UNREGULATED = 1'b0
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [bsr_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [1:0]                  supervisor_config_mode,
  input  wire logic                        supervisor_active,
  input  wire logic                        other_reset,
  input  wire logic                        sleep_req,
  input  wire logic                        wake_evt,
  input  wire logic [3:0]                  incompat_periph_en,
  input  wire logic                        cwu_hfosc_req,
  output logic                             supervisor_enable,
  output logic                             bandgap_force_on,
  output logic                             regulator_enable,
  output logic                             regulator_low_power,
  output logic                             hfosc_keep_on,
  output logic                             in_sleep,
  output logic                             core_run
);

  bsr_ctl_if ctl_if ();

  logic [1:0]  cfg_meta_ff;
  logic [1:0]  cfg_ff;
  logic        act_meta_ff;
  logic        act_ff;
  logic        sw_en_ff;
  logic        fs_ff;
  logic        regpm_ff;
  logic        sup_en_ff;
  logic        bg_ff;
  logic        reg_en_ff;
  logic        hfosc_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_val;

  // Tells whether the bus address selects the register at the given offset.
  function automatic logic addr_hit(input logic [bsr_pkg::ADDR_W-1:0] addr,
                                    input logic [bsr_pkg::ADDR_W-1:0] ofs);
    return (addr == ofs);
  endfunction

  bsr_sleep_seq #(
    .UNREGULATED (UNREGULATED)
  ) u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .ctl     (ctl_if.seq)
  );

  // Only incompatible peripherals reach the sequencer; supervisor, watchdog,
  // interrupt pins and the externally clocked timer are deliberately absent.
  assign ctl_if.incompat_any = |incompat_periph_en;
  assign ctl_if.sleep_req    = sleep_req;
  assign ctl_if.wake_evt     = wake_evt;
  assign ctl_if.regpm        = regpm_ff;
  assign ctl_if.other_reset  = other_reset;

  // Two-stage synchronisers for the analog-side levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_meta_ff <= bsr_pkg::CFG_RST;
      cfg_ff      <= bsr_pkg::CFG_RST;
      act_meta_ff <= 1'b0;
      act_ff      <= 1'b0;
    end else begin
      cfg_meta_ff <= supervisor_config_mode;
      cfg_ff      <= cfg_meta_ff;
      act_meta_ff <= supervisor_active;
      act_ff      <= act_meta_ff;
    end
  end

  // APB decode.
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  assign mapped = addr_hit(paddr, bsr_pkg::BOC_OFS) || addr_hit(paddr, bsr_pkg::REG_OFS)
                  || addr_hit(paddr, bsr_pkg::STAT_OFS);

  // Brownout control bits survive every reset except the power resets.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_en_ff <= bsr_pkg::SW_EN_RST;
      fs_ff    <= bsr_pkg::FS_RST;
    end else if (wr_en && addr_hit(paddr, bsr_pkg::BOC_OFS)) begin
      sw_en_ff <= pwdata[bsr_pkg::SW_EN_BIT];
      fs_ff    <= pwdata[bsr_pkg::FS_BIT];
    end
  end

  // Regulator power-select bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regpm_ff <= bsr_pkg::REGPM_RST;
    end else if (other_reset) begin
      regpm_ff <= bsr_pkg::REGPM_RST;
    end else if (wr_en && addr_hit(paddr, bsr_pkg::REG_OFS)) begin
      regpm_ff <= pwdata[bsr_pkg::REGPM_BIT];
    end
  end

  // Supervisor enable and band gap forcing from the configuration field.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_en_ff <= 1'b0;
      bg_ff     <= 1'b0;
    end else begin
      unique case (bsr_pkg::bsr_cfg_mode_t'(cfg_ff))
        bsr_pkg::CFG_OFF: begin
          sup_en_ff <= 1'b0;
          bg_ff     <= 1'b0;
        end
        bsr_pkg::CFG_SW: begin
          sup_en_ff <= sw_en_ff;
          bg_ff     <= fs_ff;
        end
        bsr_pkg::CFG_NOSLEEP: begin
          sup_en_ff <= ~ctl_if.in_sleep;
          bg_ff     <= fs_ff;
        end
        bsr_pkg::CFG_ON: begin
          sup_en_ff <= 1'b1;
          bg_ff     <= 1'b0;
        end
      endcase
    end
  end

  // Regulator stays on in every state; the waveform unit may hold the oscillator.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_en_ff <= 1'b1;
      hfosc_ff  <= 1'b0;
    end else begin
      reg_en_ff <= 1'b1;
      hfosc_ff  <= ctl_if.in_sleep & cwu_hfosc_req;
    end
  end

  // Read mux.
  always_comb begin
    rd_val = 32'h0000_0000;
    if (addr_hit(paddr, bsr_pkg::BOC_OFS)) begin
      rd_val[bsr_pkg::SW_EN_BIT] = sw_en_ff;
      rd_val[bsr_pkg::FS_BIT]    = fs_ff;
      rd_val[bsr_pkg::RDY_BIT]   = act_ff;
    end else if (addr_hit(paddr, bsr_pkg::REG_OFS)) begin
      rd_val[bsr_pkg::REGPM_BIT] = regpm_ff;
    end else if (addr_hit(paddr, bsr_pkg::STAT_OFS)) begin
      rd_val[bsr_pkg::ST_SLEEP_BIT]  = ctl_if.in_sleep;
      rd_val[bsr_pkg::ST_LP_BIT]     = ctl_if.low_power;
      rd_val[bsr_pkg::ST_SETTLE_BIT] = ctl_if.settling;
      rd_val[bsr_pkg::ST_SUP_BIT]    = sup_en_ff;
      rd_val[bsr_pkg::ST_BG_BIT]     = bg_ff;
      rd_val[bsr_pkg::ST_INC_BIT]    = ctl_if.incompat_any;
      rd_val[bsr_pkg::ST_CFG_LO +: 2] = cfg_ff;
    end
  end

  // Answer is registered in the setup cycle and shown during the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= bsr_pkg::RDATA_RST;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_ff <= rd_val;
      end else if (setup) begin
        prdata_ff <= bsr_pkg::RDATA_RST;
      end
    end
  end

  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign supervisor_enable   = sup_en_ff;
  assign bandgap_force_on    = bg_ff;
  assign regulator_enable    = reg_en_ff;
  assign regulator_low_power = ctl_if.low_power;
  assign hfosc_keep_on       = hfosc_ff;
  assign in_sleep            = ctl_if.in_sleep;
  assign core_run            = ctl_if.core_run;

  sup_sw_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ff == 2'b01 |=> sup_en_ff == $past(sw_en_ff))
    else $error("supervisor does not follow software bit");

  sup_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ff[1] == cfg_ff[0] |=> sup_en_ff == $past(cfg_ff[0]))
    else $error("software bit affected fixed supervisor mode");

  bg_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ff[1] != cfg_ff[0] |=> bg_ff == $past(fs_ff))
    else $error("band gap not forced by fast start");

  bg_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ff[1] == cfg_ff[0] |=> !bg_ff)
    else $error("fast start acted in fixed mode");

  rdy_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == bsr_pkg::BOC_OFS |=> prdata_ff[0] == $past(act_ff) && pready_ff)
    else $error("ready bit not reporting supervisor state");

  resv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready_ff && addr_hit(paddr, bsr_pkg::BOC_OFS)
      |-> prdata_ff[bsr_pkg::RESV_HI:bsr_pkg::RESV_LO] == '0)
    else $error("reserved bits not zero");

  reg_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_if.in_sleep |-> reg_en_ff)
    else $error("regulator disabled in sleep");

  keep_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    other_reset && !wr_en |=> sw_en_ff == $past(sw_en_ff) && fs_ff == $past(fs_ff))
    else $error("other reset disturbed brownout bits");

  incompat_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_if.in_sleep && !UNREGULATED && $past(ctl_if.incompat_any) && $rose(ctl_if.in_sleep)
      |-> !ctl_if.low_power)
    else $error("low power with incompatible peripheral");

  hfosc_a: assert property (@(posedge pclk) disable iff (!presetn)
    hfosc_ff |-> $past(ctl_if.in_sleep) && $past(cwu_hfosc_req))
    else $error("oscillator held outside sleep request");

  ready_after_setup_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup
      |=> pready_ff)
    else $error("ready missing after setup");

  ready_single_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready_ff && psel && penable
      |=> !pready_ff)
    else $error("ready held past one access cycle");

  err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !mapped
      |=> pready_ff && pslverr_ff)
    else $error("unmapped address not flagged");

  err_mapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && mapped
      |=> !pslverr_ff)
    else $error("mapped address flagged as error");

  bc_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && addr_hit(paddr, bsr_pkg::BOC_OFS)
      |=> sw_en_ff == $past(pwdata[bsr_pkg::SW_EN_BIT])
        && fs_ff == $past(pwdata[bsr_pkg::FS_BIT]))
    else $error("brownout control write lost");

  reg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && addr_hit(paddr, bsr_pkg::REG_OFS) && !other_reset
      |=> regpm_ff == $past(pwdata[bsr_pkg::REGPM_BIT]))
    else $error("power select write lost");

  reg_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    other_reset
      |=> !regpm_ff)
    else $error("power select survived other reset");

  err_nowrite_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready_ff && pslverr_ff && !other_reset
      |=> $stable(sw_en_ff) && $stable(fs_ff) && $stable(regpm_ff))
    else $error("unmapped write changed a register");

  sup_nosleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ff == 2'b10
      |=> sup_en_ff == !$past(ctl_if.in_sleep))
    else $error("supervisor wrong in sleep-off mode");

  lp_in_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_if.low_power
      |-> ctl_if.in_sleep)
    else $error("low power outside sleep");

  run_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_if.core_run
      |-> !ctl_if.in_sleep)
    else $error("core runs while asleep");

  hfosc_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_if.in_sleep
      |=> !hfosc_ff)
    else $error("oscillator kept while awake");

  bc_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && addr_hit(paddr, bsr_pkg::BOC_OFS)
      |=> prdata_ff[bsr_pkg::SW_EN_BIT] == $past(sw_en_ff)
        && prdata_ff[bsr_pkg::FS_BIT] == $past(fs_ff))
    else $error("brownout control read wrong");

  stat_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && addr_hit(paddr, bsr_pkg::STAT_OFS)
      |=> prdata_ff[bsr_pkg::ST_SLEEP_BIT] == $past(ctl_if.in_sleep)
        && prdata_ff[bsr_pkg::ST_SUP_BIT] == $past(sup_en_ff))
    else $error("status read wrong");

  wr_data_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && pwrite
      |=> prdata_ff == bsr_pkg::RDATA_RST)
    else $error("read data not cleared on write");

  wr_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == bsr_pkg::BOC_OFS);
  lp_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    ctl_if.in_sleep && ctl_if.low_power);
  err_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    pready_ff && pslverr_ff);

endmodule

// ==== sim/bsr_ctrl_tb.sv ====
/*
  Self-checking testbench for the brown-out and sleep regulator control block.
  Assumes the design files under logic/ are compiled first and that the checks
  in them run alongside; the bench alone drives every input of the block.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module bsr_ctrl_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  cfg;
  logic        sup_act;
  logic        other_reset;
  logic        sleep_req;
  logic        wake_evt;
  logic [3:0]  incompat;
  logic        hfosc_req;
  logic        supervisor_enable;
  logic        bandgap_force_on;
  logic        regulator_enable;
  logic        regulator_low_power;
  logic        hfosc_keep_on;
  logic        in_sleep;
  logic        core_run;
  int          mismatches;
  int          num_checks;
  logic [31:0] q;
  logic        e;
  int          n;

  bsr_ctrl #(.UNREGULATED(1'b0)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supervisor_config_mode(cfg), .supervisor_active(sup_act), .other_reset(other_reset),
    .sleep_req(sleep_req), .wake_evt(wake_evt), .incompat_periph_en(incompat),
    .cwu_hfosc_req(hfosc_req), .supervisor_enable(supervisor_enable),
    .bandgap_force_on(bandgap_force_on), .regulator_enable(regulator_enable),
    .regulator_low_power(regulator_low_power), .hfosc_keep_on(hfosc_keep_on),
    .in_sleep(in_sleep), .core_run(core_run)
  );

  always #25 pclk = ~pclk;

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // One APB transfer; the request is held until the rising edge that samples
  // pready high, where read data and the error flag are taken.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
      $display("[ERR] pready expected 1 seen %b", pready);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic sleep_now();
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    tick(2);
  endtask

  // Counts the edges from raising the wake request until the core runs.
  task automatic wake_now();
    n = 0;
    wake_evt <= 1'b1;
    do begin
      @(posedge pclk);
      wake_evt <= 1'b0;
      n++;
      #1;
    end while (core_run !== 1'b1 && n < 300);
    @(posedge pclk);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    mismatches++;
    $display("[ERR] watchdog expected finish seen hang");
    results();
  end

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; cfg = 2'b00; sup_act = 1'b1;
    other_reset = 1'b0; sleep_req = 1'b0; wake_evt = 1'b0; incompat = 4'h0;
    hfosc_req = 1'b0; mismatches = 0; num_checks = 0;
    tick(10);
    presetn <= 1'b1;
    tick(4);
    // Reset values, reserved bits and the ready bit.
    apb(1'b0, bsr_pkg::BOC_OFS, 32'h0);
    `CHK("bc reset", 32'h0000_0081, q)
    apb(1'b1, bsr_pkg::BOC_OFS, 32'h0000_00ff);
    apb(1'b0, bsr_pkg::BOC_OFS, 32'h0);
    `CHK("bc reserved", 32'h0000_00c1, q)
    sup_act <= 1'b0;
    tick(4);
    apb(1'b0, bsr_pkg::BOC_OFS, 32'h0);
    `CHK("bc ready low", 32'h0000_00c0, q)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    done("register");
    // Every configuration mode against every enable and fast-start value.
    for (int c = 0; c < 4; c++) begin
      for (int v = 0; v < 4; v++) begin
        apb(1'b1, bsr_pkg::BOC_OFS, {24'h0, v[1:0], 6'h00});
        cfg <= c[1:0];
        tick(5);
        apb(1'b0, bsr_pkg::BOC_OFS, 32'h0);
        `CHK("bc stored", {24'h0, v[1:0], 6'h00}, q)
        `CHK("sup enable", (c == 0) ? 1'b0 : (c == 1) ? v[1] : 1'b1, supervisor_enable)
        `CHK("bandgap", (c == 1 || c == 2) ? v[0] : 1'b0, bandgap_force_on)
      end
    end
    done("config");
    // Normal sleep keeps the regulator in its normal state and wakes at once.
    cfg <= 2'b10;
    tick(4);
    sleep_now();
    `CHK("ns in_sleep", 1'b1, in_sleep)
    `CHK("ns sup off", 1'b0, supervisor_enable)
    `CHK("ns bandgap", 1'b1, bandgap_force_on)
    `CHK("ns low power", 1'b0, regulator_low_power)
    `CHK("ns reg on", 1'b1, regulator_enable)
    `CHK("ns core", 1'b0, core_run)
    wake_now();
    `CHK("ns fast wake", 1'b1, n <= 2)
    done("normal sleep");
    // Low-power sleep with only compatible activity and a settle on wake.
    apb(1'b1, bsr_pkg::REG_OFS, 32'h0000_0001);
    hfosc_req <= 1'b1;
    sleep_now();
    `CHK("lp low power", 1'b1, regulator_low_power)
    `CHK("lp reg on", 1'b1, regulator_enable)
    `CHK("lp osc kept", 1'b1, hfosc_keep_on)
    apb(1'b0, bsr_pkg::STAT_OFS, 32'h0);
    `CHK("lp status", 32'h0000_0093, q)
    hfosc_req <= 1'b0;
    tick(2);
    `CHK("lp osc free", 1'b0, hfosc_keep_on)
    wake_now();
    `CHK("lp settle", 101, n)
    `CHK("lp normal", 1'b0, regulator_low_power)
    done("low power sleep");
    // An incompatible peripheral holds the regulator in normal power.
    incompat <= 4'h4;
    tick(1);
    sleep_now();
    `CHK("inc in_sleep", 1'b1, in_sleep)
    `CHK("inc low power", 1'b0, regulator_low_power)
    wake_now();
    `CHK("inc fast wake", 1'b1, n <= 2)
    incompat <= 4'h0;
    done("incompatible");
    // Other reset keeps the brownout bits and clears the power-select bit; a power reset presets them.
    apb(1'b1, bsr_pkg::BOC_OFS, 32'h0000_0040);
    other_reset <= 1'b1;
    @(posedge pclk);
    other_reset <= 1'b0;
    tick(2);
    apb(1'b0, bsr_pkg::BOC_OFS, 32'h0);
    `CHK("or kept", 32'h0000_0040, q)
    apb(1'b0, bsr_pkg::REG_OFS, 32'h0);
    `CHK("or regbit", 32'h0, q)
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(4);
    apb(1'b0, bsr_pkg::BOC_OFS, 32'h0);
    `CHK("por preset", 32'h0000_0080, q)
    done("resets");
    results();
  end
endmodule
